/* File: core/cft_pkg.sv */
/*
  Constants, field layout and carrier types for the clock unit factory test register bank.
  Assumes a 32-bit classic Wishbone bus with byte addresses and one aligned word per register.
*/
package cft_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices and their byte addresses
  localparam int CFT_ADR_W = 10;
  localparam logic [7:0] CFT_IDX_CTL = 8'h3d;
  localparam logic [7:0] CFT_IDX_ALT = 8'h3e;
  localparam logic [CFT_ADR_W-1:0] CFT_ADR_CTL = {CFT_IDX_CTL, 2'h0};
  localparam logic [CFT_ADR_W-1:0] CFT_ADR_ALT = {CFT_IDX_ALT, 2'h0};

  ////////////////////////////////////////////////////////////////////////////
  // Field positions in the test control register
  localparam int CFT_BIT_MAP_SEL = 7;
  localparam int CFT_BIT_GFE = 6;
  localparam int CFT_BIT_PIN_ROUTE = 5;
  localparam int CFT_BIT_FORCE = 4;
  localparam int CFT_BIT_VCO_MSB = 3;
  localparam int CFT_BIT_RSVD = 2;
  localparam int CFT_BIT_X4 = 1;
  localparam int CFT_BIT_OSC_SQW = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset and limits of the sweep range
  localparam logic [7:0] CFT_CTL_RST = 8'h00;
  localparam logic CFT_GFE_RST = 1'h0;
  localparam logic [7:0] CFT_ALT_RST = 8'h00;
  localparam logic [7:0] CFT_AMP_RST = 8'h00;
  localparam logic [7:0] CFT_SWEEP_RST = 8'h00;
  localparam logic [7:0] CFT_SWEEP_TOP = 8'hff;
  localparam logic [7:0] CFT_SWEEP_BOT = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Carrier types
  typedef struct packed {
    logic mapSel;
    logic gfe;
    logic pinRoute;
    logic filterForce;
    logic vcoMsb;
    logic rsvd;
    logic depthX4;
    logic oscSqw;
  } cft_ctl_type;

  typedef struct packed {
    logic [7:0] modAmpCode;
    logic [11:0] modAmplitude;
    logic [2:0] vcoGainSel;
    logic filterPinRoute;
    logic filterForce;
    logic filterLevelHalf;
    logic modDepthX4;
    logic oscDigitalInEn;
    logic oscTestData;
  } cft_pll_type;

  localparam cft_pll_type CFT_PLL_RST = '{default: '0};

  typedef enum logic {SWEEP_UP, SWEEP_DOWN} cft_sweep_type;

endpackage

/* File: core/cft_sweep.sv */
/*
  Triangular sweep generator for the modulation amplitude code.
  Assumes one clock, a synchronous active-high reset and a clock enable from the parent.
*/
module cft_sweep
  import cft_pkg::*;
(
  // Clock and control
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic enable,
  // Sweep code
  output logic [7:0] code_r
);

  cft_sweep_type dir_r;

  ////////////////////////////////////////////////////////////////////////////
  // Direction turns at the top and bottom of the range
  always_ff @(posedge mclk) begin
    if (rst || (ce && !enable)) begin
      dir_r <= SWEEP_UP;
    end else if (ce) begin
      unique case (dir_r)
        SWEEP_UP: begin
          if (code_r == CFT_SWEEP_TOP - 8'h01) dir_r <= SWEEP_DOWN;
        end
        SWEEP_DOWN: begin
          if (code_r == CFT_SWEEP_BOT + 8'h01) dir_r <= SWEEP_UP;
        end
      endcase
    end
  end

  // Code steps once per enabled cycle, parks at bottom when modulation is off
  always_ff @(posedge mclk) begin
    if (rst) begin
      code_r <= CFT_SWEEP_RST;
    end else if (ce) begin
      if (!enable) code_r <= CFT_SWEEP_BOT;
      else if (dir_r == SWEEP_UP) code_r <= code_r + 8'h01;
      else code_r <= code_r - 8'h01;
    end
  end

endmodule

/* File: core/cft_test_regs.sv */
/*
  Clock unit factory test register bank: test control register and the shared alternate slot,
  with the control outputs that steer the PLL macro, loop filter and oscillator test path.
  Assumes a classic Wishbone master on mclk, mode and PLL setting bits from logic on the same
  clock, and an asynchronous crystal pin that is synchronised here.
*/
// Decided for this implementation: register access over Wishbone.

// Operation
// - Reads always; writes only in special mode
// - Select 0: alt register, swept amplitude code
// - Select 1: amplitude register, static code
// - Glitch filter bit forwarded as request
// - Glitch filter bit cleared by power-on only
// - Pin route bit connects external filter pin
// - Force bit: half or third supply level
// - Gain MSB joins synthesizer gain bits
// - Depth bit multiplies amplitude by four
// - Square-wave bit enables crystal digital input
module cft_test_regs
  import cft_pkg::*;
(
  // Clock, resets and enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic porRst,
  input wire logic ce,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [CFT_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Device state from neighbouring logic
  input wire logic specialMode,
  input wire logic referenceRangeBit1,
  input wire logic [1:0] synthGainBits,
  input wire logic [1:0] amplitudeSelectBits,
  input wire logic modulationOn,
  // Crystal pin digital level
  input wire logic xtalPin,
  // Controls to PLL, filter and oscillator
  output cft_pll_type pllCtl,
  output logic gfeRequest,
  output logic [7:0] altTestBits
);

  cft_ctl_type ctl_r;
  logic gfe_r;
  logic [7:0] amp_r;
  logic [7:0] alt_r;
  logic [7:0] sweepCode;
  logic xtalSync1_r;
  logic xtalSync2_r;
  logic busReq;
  logic wrStrobe;
  logic wrCtl;
  logic wrSlot;
  logic [7:0] rdByte;
  logic [7:0] ctlView;
  cft_pll_type pll_nxt;
  logic [9:0] ampProduct;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  // Request seen, write lands at the edge where ack is sampled high
  assign busReq = wb_cyc_i && wb_stb_i;
  assign wrStrobe = busReq && wb_we_i && wb_ack_o && wb_sel_i[0] && specialMode;
  assign wrCtl = wrStrobe && (wb_adr_i == CFT_ADR_CTL);
  assign wrSlot = wrStrobe && (wb_adr_i == CFT_ADR_ALT);

  // Control register as seen by a read, reserved bit tied low
  always_comb begin
    ctlView = ctl_r;
    ctlView[CFT_BIT_GFE] = gfe_r;
    ctlView[CFT_BIT_RSVD] = 1'b0;
  end

  // Read mux; the shared slot follows the map select, unmapped reads give zero
  always_comb begin
    rdByte = 8'h00;
    if (wb_adr_i == CFT_ADR_CTL) begin
      rdByte = ctlView;
    end else if (wb_adr_i == CFT_ADR_ALT) begin
      rdByte = ctl_r.mapSel ? amp_r : alt_r;
    end
  end

  // Ack one cycle after the request, dropped in the cycle after
  always_ff @(posedge mclk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else if (ce) begin
      wb_ack_o <= busReq && !wb_ack_o;
    end
  end

  // Read data captured with the ack
  always_ff @(posedge mclk) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_dat_o <= (busReq && !wb_ack_o) ? {24'h00_0000, rdByte} : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  // Control bits on the ordinary reset; bit 2 never stored
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctl_r <= CFT_CTL_RST;
    end else if (ce && wrCtl) begin
      ctl_r <= wb_dat_i[7:0];
      ctl_r.gfe <= 1'b0;
      ctl_r.rsvd <= 1'b0;
    end
  end

  // Glitch filter bit survives the ordinary reset
  always_ff @(posedge mclk) begin
    if (porRst) begin
      gfe_r <= CFT_GFE_RST;
    end else if (ce && wrCtl) begin
      gfe_r <= wb_dat_i[CFT_BIT_GFE];
    end
  end

  // Shared slot: the write goes to whichever register is mapped in
  always_ff @(posedge mclk) begin
    if (rst) begin
      alt_r <= CFT_ALT_RST;
    end else if (ce && wrSlot && !ctl_r.mapSel) begin
      alt_r <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      amp_r <= CFT_AMP_RST;
    end else if (ce && wrSlot && ctl_r.mapSel) begin
      amp_r <= wb_dat_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crystal pin synchroniser
  always_ff @(posedge mclk) begin
    if (rst) begin
      xtalSync1_r <= 1'b0;
      xtalSync2_r <= 1'b0;
    end else if (ce) begin
      xtalSync1_r <= xtalPin;
      xtalSync2_r <= xtalSync1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Triangular amplitude sweep
  cft_sweep u_sweep (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .enable(modulationOn),
    .code_r(sweepCode)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control outputs

  // Next value of the PLL control word
  always_comb begin
    pll_nxt = CFT_PLL_RST;
    pll_nxt.modAmpCode = ctl_r.mapSel ? amp_r : sweepCode;
    ampProduct = 10'(amplitudeSelectBits) * 10'(pll_nxt.modAmpCode);
    pll_nxt.modAmplitude = ctl_r.depthX4 ? {ampProduct, 2'b00} : {2'b00, ampProduct};
    pll_nxt.vcoGainSel = {ctl_r.vcoMsb, synthGainBits};
    pll_nxt.filterPinRoute = ctl_r.pinRoute;
    pll_nxt.filterForce = ctl_r.filterForce;
    pll_nxt.filterLevelHalf = ctl_r.filterForce && referenceRangeBit1;
    pll_nxt.modDepthX4 = ctl_r.depthX4;
    pll_nxt.oscDigitalInEn = ctl_r.oscSqw;
    pll_nxt.oscTestData = ctl_r.oscSqw && xtalSync2_r;
  end

  // Pin route and force both pass through; software keeps only one source active
  always_ff @(posedge mclk) begin
    if (rst) begin
      pllCtl <= CFT_PLL_RST;
    end else if (ce) begin
      pllCtl <= pll_nxt;
    end
  end

  // Request to the production test controller
  always_ff @(posedge mclk) begin
    if (porRst) begin
      gfeRequest <= CFT_GFE_RST;
    end else if (ce) begin
      gfeRequest <= gfe_r;
    end
  end

  // Alternate test bits to the PLL test logic
  always_ff @(posedge mclk) begin
    if (rst) begin
      altTestBits <= CFT_ALT_RST;
    end else if (ce) begin
      altTestBits <= alt_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_write_gate;
    @(posedge mclk) disable iff (rst || porRst)
    (ce && wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && !specialMode) |=> $stable(ctl_r) && $stable(gfe_r)
      && $stable(amp_r) && $stable(alt_r);
  endproperty
  a_write_gate: assert property (p_write_gate) else $error("write took effect outside special mode");

  property p_write_lands;
    @(posedge mclk) disable iff (rst || porRst)
    (ce && wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && specialMode && wb_sel_i[0]
      && wb_adr_i == CFT_ADR_CTL) |=> ctl_r.filterForce == $past(wb_dat_i[CFT_BIT_FORCE]);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("special mode write not stored");

  property p_sweep_code;
    @(posedge mclk) disable iff (rst)
    (ce && !ctl_r.mapSel) |=> pllCtl.modAmpCode == $past(sweepCode);
  endproperty
  a_sweep_code: assert property (p_sweep_code) else $error("amplitude code not from sweep");

  property p_static_code;
    @(posedge mclk) disable iff (rst)
    (ce && ctl_r.mapSel) |=> pllCtl.modAmpCode == $past(amp_r);
  endproperty
  a_static_code: assert property (p_static_code) else $error("amplitude code not from register");

  property p_slot_read;
    @(posedge mclk) disable iff (rst)
    (ce && wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i == CFT_ADR_ALT)
      |=> wb_ack_o && wb_dat_o[7:0] == ($past(ctl_r.mapSel) ? $past(amp_r) : $past(alt_r));
  endproperty
  a_slot_read: assert property (p_slot_read) else $error("shared slot read wrong register");

  property p_gfe_forward;
    @(posedge mclk) disable iff (porRst)
    ce |=> gfeRequest == $past(gfe_r);
  endproperty
  a_gfe_forward: assert property (p_gfe_forward) else $error("glitch filter request not forwarded");

  property p_gfe_keeps;
    @(posedge mclk) disable iff (porRst)
    (rst && !wrCtl) |=> gfe_r == $past(gfe_r);
  endproperty
  a_gfe_keeps: assert property (p_gfe_keeps) else $error("ordinary reset changed glitch filter bit");

  property p_filter_ctl;
    @(posedge mclk) disable iff (rst)
    ce |=> pllCtl.filterPinRoute == $past(ctl_r.pinRoute)
      && pllCtl.filterLevelHalf == ($past(ctl_r.filterForce) && $past(referenceRangeBit1));
  endproperty
  a_filter_ctl: assert property (p_filter_ctl) else $error("filter route or level wrong");

  property p_gain_sel;
    @(posedge mclk) disable iff (rst)
    (ce && !rst) |=> pllCtl.vcoGainSel == {$past(ctl_r.vcoMsb), $past(synthGainBits)};
  endproperty
  a_gain_sel: assert property (p_gain_sel) else $error("gain select wrong");

  property p_depth;
    @(posedge mclk) disable iff (rst)
    (ce && !rst && ctl_r.depthX4)
      |=> pllCtl.modAmplitude == 12'(pllCtl.modAmpCode * $past(amplitudeSelectBits) * 4);
  endproperty
  a_depth: assert property (p_depth) else $error("amplitude not multiplied by four");

  property p_osc_gate;
    @(posedge mclk) disable iff (rst)
    (ce && !ctl_r.oscSqw) |=> !pllCtl.oscTestData && !pllCtl.oscDigitalInEn;
  endproperty
  a_osc_gate: assert property (p_osc_gate) else $error("crystal digital input not disabled");

  property p_rsvd_zero;
    @(posedge mclk) disable iff (rst)
    (wb_ack_o && wb_adr_i == CFT_ADR_CTL && !wb_we_i) |-> !wb_dat_o[CFT_BIT_RSVD];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read as one");

  property p_ack_latency;
    @(posedge mclk) disable iff (rst)
    (ce && wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_latency: assert property (p_ack_latency) else $error("request not acknowledged after one cycle");

  property p_ack_pulse;
    @(posedge mclk) disable iff (rst)
    (ce && wb_ack_o) |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("acknowledge held longer than one cycle");

  property p_ctl_read;
    @(posedge mclk) disable iff (rst)
    (ce && wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i == CFT_ADR_CTL)
      |=> wb_dat_o[CFT_BIT_GFE] == $past(gfe_r) && wb_dat_o[31:8] == 24'h00_0000;
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control read lost glitch filter bit");

  property p_refused_write;
    @(posedge mclk) disable iff (rst || porRst)
    (ce && wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && !wb_sel_i[0]) |=> $stable(ctl_r) && $stable(gfe_r)
      && $stable(amp_r) && $stable(alt_r);
  endproperty
  a_refused_write: assert property (p_refused_write) else $error("write without low byte enable stored");

  property p_rst_clears;
    @(posedge mclk)
    rst |=> ctl_r == CFT_CTL_RST && pllCtl == CFT_PLL_RST && altTestBits == CFT_ALT_RST && !wb_ack_o;
  endproperty
  a_rst_clears: assert property (p_rst_clears) else $error("ordinary reset left control state set");

  property p_gfe_por;
    @(posedge mclk)
    porRst |=> !gfe_r && !gfeRequest;
  endproperty
  a_gfe_por: assert property (p_gfe_por) else $error("power-on reset left glitch filter bit set");

  property p_alt_out;
    @(posedge mclk) disable iff (rst)
    (ce && !rst) |=> altTestBits == $past(alt_r);
  endproperty
  a_alt_out: assert property (p_alt_out) else $error("alternate test bits not forwarded");

  property p_osc_data;
    @(posedge mclk) disable iff (rst)
    (ce && !rst && ctl_r.oscSqw) |=> pllCtl.oscDigitalInEn && pllCtl.oscTestData == $past(xtalSync2_r);
  endproperty
  a_osc_data: assert property (p_osc_data) else $error("crystal digital input not passed");

  property p_depth_x1;
    @(posedge mclk) disable iff (rst)
    (ce && !rst && !ctl_r.depthX4)
      |=> pllCtl.modAmplitude == 12'(pllCtl.modAmpCode * $past(amplitudeSelectBits));
  endproperty
  a_depth_x1: assert property (p_depth_x1) else $error("amplitude not multiplied by one");

endmodule

/* File: dv/cft_test_regs_tb.sv */
/*
  Self-checking bench for the clock unit factory test register bank.
  Assumes the bench alone drives every port: Wishbone master, mode and PLL setting inputs, crystal pin.
*/
module cft_test_regs_tb
  import cft_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////////////////////////////////////////
  // Stimulus, observed outputs and bench bookkeeping
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic porRst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [CFT_ADR_W-1:0] adr = '0;
  logic [3:0] sel = 4'h1;
  logic [31:0] datW = 32'h0;
  logic specialMode = 1'b0;
  logic refBit1 = 1'b0;
  logic modOn = 1'b0;
  logic xtalPin = 1'b1;
  logic [1:0] gainBits = 2'h0;
  logic [1:0] ampSel = 2'h0;
  logic ce = 1'b1;
  logic up = 1'b1;
  logic lastCe = 1'b1;
  logic [31:0] wbDatO;
  logic wbAck;
  cft_pll_type pllCtl;
  logic gfeRequest;
  logic [7:0] altTestBits;
  logic [31:0] datR;
  logic [7:0] v, a, ctlReg, ampReg, altReg, codeA;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int seed;

  cft_test_regs dut (
    .mclk(mclk), .rst(rst), .porRst(porRst), .ce(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(datW), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .specialMode(specialMode), .referenceRangeBit1(refBit1), .synthGainBits(gainBits),
    .amplitudeSelectBits(ampSel), .modulationOn(modOn), .xtalPin(xtalPin),
    .pllCtl(pllCtl), .gfeRequest(gfeRequest), .altTestBits(altTestBits)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #2 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Expectation, comparison and bus tasks
  function automatic logic [11:0] exp_amp(input logic [1:0] s, input logic [7:0] c, input logic x4);
    logic [11:0] p;
    p = {10'h0, s} * {4'h0, c};
    return x4 ? {p[9:0], 2'h0} : p;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Classic single cycle; request held until ack is sampled high at a rising edge, data taken there
  task automatic bus(input logic w, input logic [CFT_ADR_W-1:0] ad, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    datW <= {24'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      stop_test();
    end else begin
      datR = wbDatO;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
    end
  endtask

  task automatic wr(input logic [CFT_ADR_W-1:0] ad, input logic [7:0] d);
    bus(1'b1, ad, d);
  endtask

  task automatic rd_chk(input logic [CFT_ADR_W-1:0] ad, input logic [7:0] exp);
    bus(1'b0, ad, 8'h00);
    check(datR, {24'h0, exp});
  endtask

  // Control outputs after the register and its output stage have settled
  task automatic outs();
    repeat (2) @(posedge mclk);
    check(pllCtl.filterPinRoute, ctlReg[5]);
    check(pllCtl.filterForce, ctlReg[4]);
    check(pllCtl.filterLevelHalf, ctlReg[4] & refBit1);
    check(pllCtl.vcoGainSel, {ctlReg[3], gainBits});
    check(pllCtl.modDepthX4, ctlReg[1]);
    check(pllCtl.modAmplitude, exp_amp(ampSel, ctlReg[7] ? ampReg : 8'h00, ctlReg[1]));
    check(pllCtl.oscDigitalInEn, ctlReg[0]);
    check(pllCtl.oscTestData, ctlReg[0] & xtalPin);
    check(gfeRequest, ctlReg[6]);
    check(altTestBits, altReg);
    check(pllCtl.modAmpCode, ctlReg[7] ? ampReg : 8'h00);
  endtask

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = $urandom(32'h9b5a);
    ctlReg = 8'h00;
    ampReg = 8'h00;
    altReg = 8'h00;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    porRst <= 1'b0;
    rd_chk(CFT_ADR_CTL, 8'h00);
    rd_chk(CFT_ADR_ALT, 8'h00);
    outs();
    $display("test reset values done");
    // Refused writes: normal mode, then low byte not enabled, then the unused bit
    wr(CFT_ADR_CTL, 8'hff);
    rd_chk(CFT_ADR_CTL, 8'h00);
    specialMode <= 1'b1;
    sel <= 4'h0;
    wr(CFT_ADR_CTL, 8'hff);
    rd_chk(CFT_ADR_CTL, 8'h00);
    sel <= 4'h1;
    wr(CFT_ADR_CTL, 8'h04);
    rd_chk(CFT_ADR_CTL, 8'h00);
    $display("test refused writes done");
    // Random settings through both meanings of the shared slot
    for (int i = 0; i < 12; i++) begin
      v = 8'($urandom);
      if (v[5]) v[4] = 1'b0;
      a = 8'($urandom);
      refBit1 <= 1'($urandom);
      gainBits <= 2'($urandom);
      ampSel <= 2'($urandom);
      xtalPin <= 1'($urandom);
      wr(CFT_ADR_CTL, v);
      ctlReg = v & 8'hfb;
      wr(CFT_ADR_ALT, a);
      if (v[7]) ampReg = a;
      else altReg = a;
      rd_chk(CFT_ADR_CTL, ctlReg);
      rd_chk(CFT_ADR_ALT, v[7] ? ampReg : altReg);
      outs();
    end
    $display("test random settings done");
    // Sweep walked over both turns with select 0, frozen while ce is low; static code with select 1
    wr(CFT_ADR_CTL, 8'h00);
    ctlReg = 8'h00;
    modOn <= 1'b1;
    repeat (3) @(posedge mclk);
    codeA = 8'h01;
    check(pllCtl.modAmpCode, codeA);
    for (int j = 0; j < 600; j++) begin
      ce <= (j < 300 || j > 303);
      @(posedge mclk);
      if (lastCe) begin
        codeA = up ? codeA + 8'h01 : codeA - 8'h01;
        if (codeA == CFT_SWEEP_TOP) up = 1'b0;
        else if (codeA == CFT_SWEEP_BOT) up = 1'b1;
      end
      check(pllCtl.modAmpCode, codeA);
      lastCe = (j < 300 || j > 303);
    end
    modOn <= 1'b0;
    repeat (3) @(posedge mclk);
    check(pllCtl.modAmpCode, 8'h00);
    wr(CFT_ADR_CTL, 8'h80);
    ctlReg = 8'h80;
    modOn <= 1'b1;
    outs();
    modOn <= 1'b0;
    $display("test sweep done");
    // Ordinary reset keeps the glitch bit, power-on reset clears it
    wr(CFT_ADR_CTL, 8'h40);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd_chk(CFT_ADR_CTL, 8'h40);
    check(gfeRequest, 1'b1);
    porRst <= 1'b1;
    repeat (2) @(posedge mclk);
    porRst <= 1'b0;
    rd_chk(CFT_ADR_CTL, 8'h00);
    check(gfeRequest, 1'b0);
    rd_chk(10'h3fc, 8'h00);
    $display("test resets done");
    stop_test();
  end
endmodule
